// ==== src/dip_restart.sv ====
// Function
// RULE_01 - Any low phase drops contactor, times loss
// RULE_02 - Pickup 0.50..1.00, below restore level; a misordered pair is used unchecked
// RULE_03 - Restored only when all phases high
// RULE_04 - Loss sorted immediate, first, second delay
// RULE_05 - Restore inside immediate window restarts now
// RULE_06 - Immediate window Off never restarts immediately
// RULE_07 - Delayed window restarts after its delay
// RULE_08 - First loss window 0.1..10 s, 0 Off
// RULE_09 - Second window 1..3600 s, 3601 unlimited
// RULE_10 - Restart delays 0..1200 s, 0.2 s steps
// RULE_11 - New loss during delay restarts whole sequence; code clears imm_ok_q there, so no immediate restart follows
// RULE_12 - Assigned trip output after trip delay
// RULE_13 - Healthy hold time before next immediate restart
// RULE_14 - Any non-undervoltage trip blocks dip restart
// RULE_15 - Enabled dip restart inhibits general autorestart
// RULE_16 - Needs option fitted and voltage sensing connected
// RULE_17 - Starter status wired to spare switch input
// RULE_18 - Trip reset mode and start output assigned
// RULE_19 - Delay classes pick delays, else no restart
// RULE_20 - One common 0.1 s tick drives timers
module dip_restart
    import dip_pkg::*;
#(
    parameter int TICK_CYCLES = dip_pkg::TICK_CYCLES_DEF
) (
    input  wire logic        core_clk,
    input  wire logic        resetn,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [7:0]  vab_mag,
    input  wire logic [7:0]  vbc_mag,
    input  wire logic [7:0]  vca_mag,
    input  wire logic        other_trip,
    input  wire logic        option_fitted,
    input  wire logic        starter_status,
    output logic             contactor_drop,
    output logic [2:0]       dip_trip_out,
    output logic             start_control,
    output logic             general_ar_uv_inhibit
);
    import dip_pkg::*;

    // Prescaler needs at least two states to make a tick
    if (TICK_CYCLES < 2) begin : g_tick_check
        $error("TICK_CYCLES out of range");
    end

    // Register file: one array, masked per register
    logic [31:0] regs_q [N_REGS];
    logic [31:0] status_w;
    logic [31:0] wr_mask [N_REGS];
    assign wr_mask = '{MASK_CTRL, MASK_LVL, MASK_IMMED, MASK_D1L, MASK_12,
                       MASK_13, MASK_13, MASK_12, MASK_13, 32'h0};

    // AXI4-Lite write: address and data taken together, one outstanding
    logic        bvalid_q;
    logic [1:0]  bresp_q;
    logic        rvalid_q;
    logic [1:0]  rresp_q;
    logic [31:0] rdata_q;
    wire         wr_go   = s_axi_awvalid & s_axi_wvalid & ~bvalid_q;
    wire  [5:0]  wr_idx  = s_axi_awaddr[7:2];
    wire         wr_hit  = wr_idx < 6'(N_REGS);
    wire         rd_go   = s_axi_arvalid & ~rvalid_q;
    wire  [5:0]  rd_idx  = s_axi_araddr[7:2];
    wire         rd_hit  = rd_idx < 6'(N_REGS);
    wire  [31:0] strb_m  = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}},
                            {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
    wire  [31:0] rd_word = !rd_hit ? 32'h0 :
                           (rd_idx == 6'(IDX_STATUS)) ? status_w : regs_q[rd_idx[3:0]];

    assign s_axi_awready = wr_go;
    assign s_axi_wready  = wr_go;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = rd_go;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rresp   = rresp_q;
    assign s_axi_rdata   = rdata_q;

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < N_REGS; i++) begin
                regs_q[i] <= 32'h0;
            end
            regs_q[1] <= RST_LEVELS;
            regs_q[5] <= RST_D1_DELAY;
            regs_q[6] <= RST_D2_DELAY;
            regs_q[8] <= RST_HOLD_TIME;
        end else if (wr_go && wr_hit) begin
            regs_q[wr_idx[3:0]] <= (regs_q[wr_idx[3:0]] & ~(strb_m & wr_mask[wr_idx[3:0]]))
                                 | (s_axi_wdata & strb_m & wr_mask[wr_idx[3:0]]);
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            bvalid_q <= 1'b0;
            bresp_q  <= RESP_OKAY;
            rvalid_q <= 1'b0;
            rresp_q  <= RESP_OKAY;
            rdata_q  <= 32'h0;
        end else begin
            if (wr_go) begin
                bvalid_q <= 1'b1;
                bresp_q  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                bvalid_q <= 1'b0;
            end
            if (rd_go) begin
                rvalid_q <= 1'b1;
                rresp_q  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
                rdata_q  <= rd_word;
            end else if (s_axi_rready) begin
                rvalid_q <= 1'b0;
            end
        end
    end

    // Settings
    wire         set_en     = regs_q[0][CTRL_EN_POS];
    wire  [1:0]  set_vt     = regs_q[0][CTRL_VT_POS +: 2];
    wire  [2:0]  set_tsel   = regs_q[0][CTRL_TSEL_POS +: 3];
    wire  [7:0]  set_pick   = regs_q[1][LVL_PICK_POS +: 8];
    wire  [7:0]  set_rest   = regs_q[1][LVL_RESTORE_POS +: 8];
    wire  [2:0]  set_immed  = regs_q[2][2:0];
    wire  [6:0]  set_d1loss = regs_q[3][6:0];
    wire  [11:0] set_d2loss = regs_q[4][11:0];
    wire  [12:0] set_d1dly  = regs_q[5][12:0];
    wire  [12:0] set_d2dly  = regs_q[6][12:0];
    wire  [11:0] set_trip   = regs_q[7][11:0];
    wire  [12:0] set_hold   = regs_q[8][12:0];

    // Pin synchronisers
    logic [1:0] opt_sync_q;
    logic [1:0] starter_sync_q;
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            opt_sync_q     <= 2'b00;
            starter_sync_q <= 2'b00;
        end else begin
            opt_sync_q     <= {opt_sync_q[0], option_fitted};
            starter_sync_q <= {starter_sync_q[0], starter_status};
        end
    end
    wire starter_closed = starter_sync_q[1]; // RULE_17

    wire avail  = opt_sync_q[1] & (set_vt != 2'b00); // RULE_16
    wire active = set_en & avail & ~other_trip; // RULE_14
    assign general_ar_uv_inhibit = set_en & avail; // RULE_15

    // Levels in hundredths of rated; a misordered pair is used unchecked and can still restart
    wire any_low  = (vab_mag < set_pick) | (vbc_mag < set_pick) | (vca_mag < set_pick); // RULE_01
    wire all_high = (vab_mag > set_rest) & (vbc_mag > set_rest) & (vca_mag > set_rest); // RULE_03

    // Common 0.1 s tick; free running, so timings carry up to one tick of jitter
    logic [31:0] pre_q;
    wire         tick = (pre_q == 32'(TICK_CYCLES - 1)); // RULE_20
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            pre_q <= 32'h0;
        end else begin
            pre_q <= tick ? 32'h0 : pre_q + 32'h1;
        end
    end

    dip_state_e  state_q;
    loss_class_e class_q;
    logic [15:0] loss_q;
    logic [13:0] dly_q;
    logic [13:0] dly_tgt_q;
    logic [13:0] healthy_q;
    logic        imm_ok_q;

    wire [15:0] d2_ticks  = 16'(set_d2loss) * 16'h000A;
    wire        imm_fit   = (set_immed != 3'h0) & imm_ok_q & (loss_q < 16'(set_immed)); // RULE_05 RULE_06
    wire        d1_fit    = (set_d1loss != 7'h0) & (loss_q < 16'(set_d1loss)); // RULE_08
    wire        d2_fit    = (set_d2loss != 12'h0)
                          & ((set_d2loss >= D2_UNLIMITED) | (loss_q < d2_ticks)); // RULE_09
    wire        healthy   = healthy_q >= {set_hold, 1'b0}; // RULE_13
    wire        loss_on   = (state_q == ST_LOSS);

    // Healthy-supply timer, in 0.1 s ticks, saturating
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            healthy_q <= 14'h0;
        end else if (!all_high) begin
            healthy_q <= 14'h0;
        end else if (tick && healthy_q != 14'h3FFF) begin
            healthy_q <= healthy_q + 14'h1;
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            state_q   <= ST_ARMED;
            class_q   <= CL_NONE;
            loss_q    <= 16'h0;
            dly_q     <= 14'h0;
            dly_tgt_q <= 14'h0;
            imm_ok_q  <= 1'b0;
        end else if (!active) begin
            state_q <= ST_ARMED; // RULE_14
        end else begin
            case (state_q)
                ST_ARMED: begin
                    if (any_low) begin
                        state_q  <= ST_LOSS; // RULE_01
                        loss_q   <= 16'h0;
                        imm_ok_q <= healthy; // RULE_13
                    end
                end
                ST_LOSS: begin
                    if (tick && loss_q != 16'hFFFF) begin
                        loss_q <= loss_q + 16'h1;
                    end
                    if (all_high) begin // RULE_03
                        dly_q <= 14'h0;
                        if (imm_fit) begin
                            class_q <= CL_IMMED; // RULE_04
                            state_q <= ST_RESTART;
                            dly_tgt_q <= 14'(START_PULSE_TICKS);
                        end else if (d1_fit) begin
                            class_q   <= CL_DELAY1; // RULE_19
                            state_q   <= ST_DELAY;
                            dly_tgt_q <= {set_d1dly, 1'b0}; // RULE_10
                        end else if (d2_fit) begin
                            class_q   <= CL_DELAY2; // RULE_19
                            state_q   <= ST_DELAY;
                            dly_tgt_q <= {set_d2dly, 1'b0}; // RULE_10
                        end else begin
                            class_q <= CL_NONE; // RULE_19
                            state_q <= ST_ARMED;
                        end
                    end
                end
                ST_DELAY: begin
                    if (any_low) begin
                        state_q  <= ST_LOSS; // RULE_11
                        loss_q   <= 16'h0;
                        dly_q    <= 14'h0;
                        imm_ok_q <= 1'b0;
                    end else if (dly_q >= dly_tgt_q) begin
                        state_q   <= ST_RESTART; // RULE_07
                        dly_q     <= 14'h0;
                        dly_tgt_q <= 14'(START_PULSE_TICKS);
                    end else if (tick) begin
                        dly_q <= dly_q + 14'h1;
                    end
                end
                ST_RESTART: begin
                    // Pulse ends once the starter reports closed, or after a fixed time
                    if (any_low) begin
                        state_q  <= ST_LOSS;
                        loss_q   <= 16'h0;
                        dly_q    <= 14'h0;
                        imm_ok_q <= healthy;
                    end else if (starter_closed || dly_q >= dly_tgt_q) begin
                        state_q <= ST_ARMED;
                        dly_q   <= 14'h0;
                    end else if (tick) begin
                        dly_q <= dly_q + 14'h1;
                    end
                end
                default: state_q <= ST_ARMED;
            endcase
        end
    end

    // Outputs from flip-flops
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            contactor_drop <= 1'b0;
            dip_trip_out   <= 3'b000;
            start_control  <= 1'b0;
        end else begin
            contactor_drop <= active & (any_low | (state_q == ST_LOSS)
                              | (state_q == ST_DELAY)); // RULE_01
            dip_trip_out   <= (active & loss_on & (loss_q >= 16'(set_trip)))
                              ? set_tsel : 3'b000; // RULE_12
            start_control  <= active & (state_q == ST_RESTART) & ~any_low; // RULE_05 RULE_07
        end
    end

    assign status_w = 32'(state_q) << ST_STATE_POS | 32'(contactor_drop) << ST_DROP_POS
                    | 32'(dip_trip_out) << ST_TRIP_POS | 32'(start_control) << ST_START_POS
                    | 32'(healthy) << ST_HEALTHY_POS | 32'(class_q) << ST_CLASS_POS
                    | 32'(starter_closed) << ST_STARTER_POS | 32'(avail) << ST_AVAIL_POS;
endmodule : dip_restart

// ==== src/dip_pkg.sv ====
package dip_pkg;
    // Register byte offsets
    localparam logic [7:0] ADDR_CTRL      = 8'h00;
    localparam logic [7:0] ADDR_LEVELS    = 8'h04;
    localparam logic [7:0] ADDR_IMMED     = 8'h08;
    localparam logic [7:0] ADDR_D1_LOSS   = 8'h0C;
    localparam logic [7:0] ADDR_D2_LOSS   = 8'h10;
    localparam logic [7:0] ADDR_D1_DELAY  = 8'h14;
    localparam logic [7:0] ADDR_D2_DELAY  = 8'h18;
    localparam logic [7:0] ADDR_TRIP_DLY  = 8'h1C;
    localparam logic [7:0] ADDR_HOLD_TIME = 8'h20;
    localparam logic [7:0] ADDR_STATUS    = 8'h24;
    localparam int         N_REGS         = 10;
    localparam int         IDX_STATUS     = 9;

    // Field positions
    localparam int CTRL_EN_POS     = 0;
    localparam int CTRL_VT_POS     = 1;
    localparam int CTRL_TSEL_POS   = 3;
    localparam int LVL_PICK_POS    = 0;
    localparam int LVL_RESTORE_POS = 8;
    localparam int ST_STATE_POS    = 0;
    localparam int ST_DROP_POS     = 2;
    localparam int ST_TRIP_POS     = 3;
    localparam int ST_START_POS    = 6;
    localparam int ST_HEALTHY_POS  = 7;
    localparam int ST_CLASS_POS    = 8;
    localparam int ST_STARTER_POS  = 10;
    localparam int ST_AVAIL_POS    = 11;

    // Reset values
    localparam logic [31:0] RST_CTRL      = 32'h0000_0000;
    localparam logic [31:0] RST_LEVELS    = 32'h0000_5A41;
    localparam logic [31:0] RST_IMMED     = 32'h0000_0000;
    localparam logic [31:0] RST_D1_LOSS   = 32'h0000_0000;
    localparam logic [31:0] RST_D2_LOSS   = 32'h0000_0000;
    localparam logic [31:0] RST_D1_DELAY  = 32'h0000_000A;
    localparam logic [31:0] RST_D2_DELAY  = 32'h0000_0032;
    localparam logic [31:0] RST_TRIP_DLY  = 32'h0000_0000;
    localparam logic [31:0] RST_HOLD_TIME = 32'h0000_0032;

    // Writable bits per register
    localparam logic [31:0] MASK_CTRL  = 32'h0000_003F;
    localparam logic [31:0] MASK_LVL   = 32'h0000_FFFF;
    localparam logic [31:0] MASK_IMMED = 32'h0000_0007;
    localparam logic [31:0] MASK_D1L   = 32'h0000_007F;
    localparam logic [31:0] MASK_12    = 32'h0000_0FFF;
    localparam logic [31:0] MASK_13    = 32'h0000_1FFF;

    // Timing
    localparam int CLK_HZ            = 40_000_000;
    localparam int TICK_MS           = 100;
    localparam int TICK_CYCLES_DEF   = CLK_HZ / 1000 * TICK_MS;
    localparam int START_PULSE_TICKS = 10;
    localparam logic [11:0] D2_UNLIMITED = 12'hE11;

    localparam logic [1:0] RESP_OKAY   = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [1:0] {ST_ARMED, ST_LOSS, ST_DELAY, ST_RESTART} dip_state_e;
    typedef enum logic [1:0] {CL_NONE, CL_IMMED, CL_DELAY1, CL_DELAY2} loss_class_e;
endpackage : dip_pkg

// ==== tb/dip_restart_props.sv ====
module dip_restart_props #(
    parameter int TICK_CYCLES = 4
) (
    input wire logic        core_clk,
    input wire logic        resetn,
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [7:0]  vab_mag,
    input wire logic [7:0]  vbc_mag,
    input wire logic [7:0]  vca_mag,
    input wire logic        other_trip,
    input wire logic        option_fitted,
    input wire logic        contactor_drop,
    input wire logic [2:0]  dip_trip_out,
    input wire logic        start_control,
    input wire logic        general_ar_uv_inhibit
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HI_MAX = 10 * TICK_CYCLES + 2;
    logic [5:0]  ctl_q;
    logic [15:0] lvl_q;
    logic [1:0]  opt_q;
    logic [7:0]  hi_q;
    // Shadow of settings; assumes full-word strobes on these two registers
    wire wr_go = s_axi_awvalid && s_axi_wvalid && s_axi_awready;
    wire avail = ctl_q[0] && opt_q[1] && ctl_q[2:1] != 2'h0;
    wire act = avail && !other_trip;
    wire any_low = vab_mag < lvl_q[7:0] || vbc_mag < lvl_q[7:0] || vca_mag < lvl_q[7:0];
    wire all_high = vab_mag > lvl_q[15:8] && vbc_mag > lvl_q[15:8] && vca_mag > lvl_q[15:8];
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ctl_q <= 6'h00;
            lvl_q <= 16'h5A41;
            opt_q <= 2'h0;
            hi_q  <= 8'h00;
        end else begin
            if (wr_go && s_axi_awaddr[7:2] == 6'h00) ctl_q <= s_axi_wdata[5:0];
            if (wr_go && s_axi_awaddr[7:2] == 6'h01) lvl_q <= s_axi_wdata[15:0];
            opt_q <= {opt_q[0], option_fitted};
            hi_q  <= start_control ? hi_q + 8'h01 : 8'h00;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    a_drop_on_dip: assert property (act && any_low |=> contactor_drop)
        else $error("contactor not dropped after dip");
    a_drop_cause: assert property ($rose(contactor_drop) |-> $past(act && any_low))
        else $error("contactor dropped without dip");
    a_loss_holds: assert property (contactor_drop && act && !all_high && !$past(all_high)
        |=> contactor_drop)
        else $error("loss ended before all phases recovered");
    a_trip_select: assert property (dip_trip_out != 3'h0
        |-> dip_trip_out == ctl_q[5:3] && contactor_drop)
        else $error("trip output does not match selection");
    a_other_trip_blocks: assert property (other_trip
        |=> !contactor_drop && !start_control && dip_trip_out == 3'h0)
        else $error("output active despite other trip");
    a_inhibit_match: assert property (general_ar_uv_inhibit == avail)
        else $error("general restart inhibit wrong");
    a_unavail_quiet: assert property (!avail |=> !contactor_drop && !start_control)
        else $error("output active while unavailable");
    a_pulse_bound: assert property (hi_q <= HI_MAX)
        else $error("restart pulse too long");
    a_write_answer: assert property (wr_go |=> s_axi_bvalid)
        else $error("write response missing");
    a_read_stable: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data changed before taken");
    c_restart: cover property ($rose(start_control));
    c_trip: cover property (dip_trip_out != 3'h0);
    c_block: cover property (other_trip && contactor_drop);
endmodule : dip_restart_props

bind dip_restart dip_restart_props #(.TICK_CYCLES(TICK_CYCLES)) u_props (
    .core_clk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wvalid, .s_axi_bvalid, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .vab_mag,
    .vbc_mag, .vca_mag, .other_trip, .option_fitted, .contactor_drop, .dip_trip_out,
    .start_control, .general_ar_uv_inhibit
);

// ==== tb/dip_contactor_model.sv ====
module dip_contactor_model (
    input  wire logic       core_clk,
    input  wire logic       resetn,
    input  wire logic       start_control,
    input  wire logic       contactor_drop,
    input  wire logic [5:0] close_dly,
    output logic            starter_status
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [5:0] hold_q;
    // Coil pulls in only after close_dly cycles of start command
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            hold_q         <= 6'h00;
            starter_status <= 1'b1;
        end else if (contactor_drop) begin
            hold_q         <= 6'h00;
            starter_status <= 1'b0;
        end else if (start_control) begin
            hold_q <= hold_q + 6'h01;
            if (hold_q >= close_dly) starter_status <= 1'b1;
        end else begin
            hold_q <= 6'h00;
        end
    end
endmodule : dip_contactor_model

// ==== tb/test_dip_restart.sv ====
module test_dip_restart;
    timeunit 1ns;
    timeprecision 1ps;
    import dip_pkg::*;
    localparam int TK = 4;
    typedef struct packed {logic [31:0] d; logic [31:0] m; logic [1:0] r;} note_s;
    logic        core_clk, resetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic        s_axi_rready, other_trip, option_fitted, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, starter_status, contactor_drop;
    logic        start_control, general_ar_uv_inhibit;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, vab_mag, vbc_mag, vca_mag;
    logic [31:0] s_axi_wdata, s_axi_rdata, seed;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [2:0]  dip_trip_out;
    logic [5:0]  close_dly;
    int          fails, total_checks, k;
    note_s       bq[$], rq[$], e;
    dip_restart #(.TICK_CYCLES(TK)) u_dut (
        .core_clk, .resetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .vab_mag, .vbc_mag, .vca_mag,
        .other_trip, .option_fitted, .starter_status, .contactor_drop, .dip_trip_out,
        .start_control, .general_ar_uv_inhibit
    );
    dip_contactor_model u_ctr (
        .core_clk, .resetn, .start_control, .contactor_drop, .close_dly, .starter_status
    );
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    task automatic results();
        $display("checks %0d, mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : results
    task automatic chk(string nm, logic [31:0] x, logic [31:0] s);
        total_checks++;
        if (s !== x) begin
            fails++;
            $display("unexpected %s: expected %h, seen %h", nm, x, s);
        end
    endtask : chk
    function automatic logic [7:0] rnd(int base, int span);
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return 8'(base + seed % span);
    endfunction : rnd
    task automatic cyc(int c);
        repeat (c) @(posedge core_clk);
    endtask : cyc
    // Mid band sits between pickup and restore: neither dip nor recovery
    task automatic v(int a, int b, int c);
        @(posedge core_clk);
        vab_mag <= a == 0 ? rnd(30, 30) : a == 1 ? rnd(100, 150) : rnd(66, 20);
        vbc_mag <= b == 0 ? rnd(30, 30) : b == 1 ? rnd(100, 150) : rnd(66, 20);
        vca_mag <= c == 0 ? rnd(30, 30) : c == 1 ? rnd(100, 150) : rnd(66, 20);
    endtask : v
    task automatic hs(ref logic sig);
        int n;
        n = 0;
        do begin
            @(posedge core_clk);
            n++;
        end while (sig !== 1'b1 && n < 50);
        if (sig !== 1'b1) begin
            fails++;
            results();
        end
    endtask : hs
    task automatic wr(logic [7:0] a, logic [31:0] d, logic [3:0] s = 4'hF,
                      logic [1:0] r = RESP_OKAY);
        bq.push_back('{32'h0, 32'h0, r});
        @(posedge core_clk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= d;
        s_axi_wstrb   <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        hs(s_axi_awready);
        chk("wready", 1, s_axi_wready);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid  <= 1'b0;
        hs(s_axi_bvalid);
    endtask : wr
    task automatic rd(logic [7:0] a, logic [31:0] d, logic [31:0] m = 32'hFFFF_FFFF,
                      logic [1:0] r = RESP_OKAY);
        rq.push_back('{d, m, r});
        @(posedge core_clk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b0;
        hs(s_axi_arready);
        s_axi_arvalid <= 1'b0;
        @(posedge core_clk);
        s_axi_rready  <= 1'b1;
        hs(s_axi_rvalid);
    endtask : rd
    task automatic wt(int lim);
        k = 0;
        while (start_control !== 1'b1 && k < lim) begin
            @(posedge core_clk);
            k++;
        end
    endtask : wt
    always @(posedge core_clk) begin
        if (s_axi_bvalid && s_axi_bready) begin
            e = bq.pop_front();
            chk("bresp", e.r, s_axi_bresp);
        end
        if (s_axi_rvalid && s_axi_rready) begin
            e = rq.pop_front();
            chk("rresp", e.r, s_axi_rresp);
            chk("rdata", e.d, s_axi_rdata & e.m);
        end
    end
    initial begin
        seed = 32'h405B_8CA1;
        fails = 0;
        total_checks = 0;
        resetn = 1'b0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, other_trip} = 4'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wstrb, s_axi_wdata} = '0;
        {s_axi_bready, s_axi_rready, option_fitted} = 3'h7;
        {vab_mag, vbc_mag, vca_mag} = {3{8'hC8}};
        close_dly = 6'h02;
        cyc(20);
        resetn <= 1'b1;
        rd(ADDR_CTRL, RST_CTRL);
        rd(ADDR_LEVELS, RST_LEVELS);
        rd(ADDR_D2_DELAY, RST_D2_DELAY);
        rd(ADDR_HOLD_TIME, RST_HOLD_TIME);
        rd(8'h28, 32'h0, 32'hFFFF_FFFF, RESP_SLVERR);
        wr(8'h2C, 32'h1, 4'hF, RESP_SLVERR);
        wr(ADDR_STATUS, 32'hFFF);
        rd(ADDR_STATUS, 32'h0, 32'h37F);
        wr(ADDR_D1_DELAY, 32'h1234, 4'h1);
        rd(ADDR_D1_DELAY, 32'h34);
        wr(ADDR_LEVELS, 32'h5A41);
        wr(ADDR_IMMED, 32'h3);
        wr(ADDR_D1_LOSS, 32'hA);
        wr(ADDR_D1_DELAY, 32'h2);
        wr(ADDR_D2_DELAY, 32'h1);
        wr(ADDR_TRIP_DLY, 32'h2);
        wr(ADDR_HOLD_TIME, 32'h14);
        wr(ADDR_CTRL, 32'h2B);
        cyc(200);
        chk("inhibit", 1, general_ar_uv_inhibit);
        v(0, 1, 1);
        cyc(2);
        chk("drop", 1, contactor_drop);
        v(1, 1, 1);
        wt(20);
        chk("start", 1, start_control);
        rd(ADDR_STATUS, 32'h100, 32'h300);
        cyc(20);
        v(1, 0, 1);
        cyc(2);
        v(1, 1, 1);
        wt(8);
        chk("start", 0, start_control);
        rd(ADDR_STATUS, 32'h200, 32'h300);
        wt(60);
        chk("start", 1, start_control);
        cyc(20);
        v(0, 0, 1);
        cyc(3);
        chk("trip", 0, dip_trip_out);
        cyc(17);
        chk("trip", 5, dip_trip_out);
        v(1, 1, 1);
        cyc(3);
        v(1, 1, 0);
        cyc(2);
        chk("drop", 1, contactor_drop);
        rd(ADDR_STATUS, 32'h1, 32'h3);
        v(1, 1, 1);
        wt(60);
        chk("wait", 1, k > 11);
        close_dly <= 6'h32;
        wr(ADDR_D2_LOSS, 32'hE11);
        v(0, 1, 1);
        cyc(60);
        v(1, 1, 1);
        rd(ADDR_STATUS, 32'h300, 32'h300);
        wt(40);
        chk("start", 1, start_control);
        cyc(50);
        wr(ADDR_D2_LOSS, 32'h1);
        v(0, 1, 1);
        cyc(8);
        v(1, 2, 1);
        cyc(40);
        chk("drop", 1, contactor_drop);
        v(1, 1, 1);
        wt(40);
        chk("start", 0, start_control);
        rd(ADDR_STATUS, 32'h0, 32'h3);
        wr(ADDR_IMMED, 32'h0);
        wr(ADDR_D1_LOSS, 32'h0);
        wr(ADDR_D2_LOSS, 32'h0);
        cyc(200);
        v(0, 1, 1);
        cyc(2);
        v(1, 1, 1);
        wt(40);
        chk("start", 0, start_control);
        v(1, 0, 1);
        cyc(2);
        other_trip <= 1'b1;
        cyc(2);
        chk("drop", 0, contactor_drop);
        rd(ADDR_STATUS, 32'h0, 32'h3);
        v(1, 1, 1);
        other_trip <= 1'b0;
        option_fitted <= 1'b0;
        cyc(4);
        v(0, 1, 1);
        cyc(3);
        chk("drop", 0, contactor_drop);
        chk("inhibit", 0, general_ar_uv_inhibit);
        v(1, 1, 1);
        results();
    end
endmodule : test_dip_restart
